// file: src/emb_pkg.sv
// Purpose: shared constants and carriers for the external memory bus timing
// Assumes: one system clock, all timing in whole clock cycles
// Notes: mode codes follow the interface mode field of the config register
package emb_pkg;
  localparam logic [2:0] EMB_MODE_MUX_NB0 = 3'h1;
  localparam logic [2:0] EMB_MODE_MUX_BANK = 3'h2;
  localparam logic [2:0] EMB_MODE_MUX_NB1 = 3'h3;
  localparam logic [2:0] EMB_MODE_NMX_NB0 = 3'h5;
  localparam logic [2:0] EMB_MODE_NMX_BANK = 3'h6;
  localparam logic [2:0] EMB_MODE_NMX_NB1 = 3'h7;
  localparam int EMB_SETUP_W = 2;
  localparam int EMB_HOLD_W = 2;
  localparam int EMB_PULSE_W = 4;
  localparam int EMB_ALE_W = 2;
  localparam logic [15:0] EMB_ADDR_RESET = 16'h0000;
  localparam logic [7:0] EMB_DATA_RESET = 8'h00;

  // timing programme; pulse code n gives n+1 strobe cycles
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] setup;
    logic [3:0] pulse;
    logic [1:0] hold;
    logic [1:0] ale_high;
    logic [1:0] ale_low;
  } emb_cfg_t;

  typedef struct packed {
    logic write;
    logic short_addr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } emb_req_t;
endpackage

// file: src/emb_count.sv
// Purpose: down counter used to time each phase of a bus cycle
// Assumes: load and tick come from the same clock
// Notes: done is high while the count is zero
`default_nettype none
module emb_count
  import emb_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic load_in, // load a new count
  input wire logic [4:0] value_in, // count to load
  output logic done_out // count reached zero
);
  logic [4:0] count;

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      count <= 5'h00;
    else if (load_in)
      count <= value_in;
    else if (count != 5'h00)
      count <= count - 5'h01;
  end

  assign done_out = (count == 5'h00);
endmodule
`default_nettype wire

// file: src/emb_ctrl.sv
// Purpose: external memory bus cycle generator, muxed and non-muxed forms
// Assumes: requests come from core logic on the same clock
// Notes: read data sampled on the last strobe cycle
`default_nettype none
module emb_ctrl
  import emb_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic reset_n_in, // async reset, active low
  input wire emb_pkg::emb_cfg_t cfg_in, // timing and mode programme
  input wire logic [7:0] page_in, // bank page byte
  input wire logic req_valid_in, // start a cycle
  input wire emb_pkg::emb_req_t req_in, // cycle request
  input wire logic [7:0] ad_in, // shared or data lines input
  output logic req_ready_out, // idle, accepts request
  output logic done_out, // one-cycle end of cycle pulse
  output logic [7:0] rdata_out, // captured read data
  output logic [7:0] addr_hi_out, // upper address lines
  output logic addr_hi_oe_out, // upper address driven
  output logic [7:0] addr_lo_out, // low address lines (non-muxed)
  output logic addr_lo_oe_out, // low address driven
  output logic [7:0] ad_out, // data or shared lines out
  output logic ad_oe_out, // data or shared lines driven
  output logic ale_out, // address latch enable
  output logic wr_n_out, // write strobe, active low
  output logic rd_n_out // read strobe, active low
);
  typedef enum {
    EMB_IDLE,
    EMB_ALE_HI,
    EMB_ALE_LO,
    EMB_SETUP,
    EMB_STROBE,
    EMB_HOLD
  } emb_state_t;

  emb_state_t state;
  emb_state_t next_state;
  emb_cfg_t cfg;
  emb_req_t req;
  logic muxed;
  logic bank;
  logic cnt_load;
  logic [4:0] cnt_value;
  logic cnt_done;

  // ************************************************************
  // mode decode
  // ************************************************************
  function automatic logic is_muxed(input logic [2:0] mode);
    is_muxed = !mode[2];
  endfunction

  function automatic logic is_bank(input logic [2:0] mode);
    is_bank = (mode == EMB_MODE_MUX_BANK) || (mode == EMB_MODE_NMX_BANK);
  endfunction

  assign muxed = is_muxed(cfg.mode);
  assign bank = is_bank(cfg.mode);

  emb_count u_count (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .load_in(cnt_load),
    .value_in(cnt_value),
    .done_out(cnt_done)
  );

  // ************************************************************
  // phase sequencing
  // ************************************************************
  always_comb
  begin
    next_state = state;
    cnt_load = 1'b0;
    cnt_value = 5'h00;
    case (state)
      EMB_IDLE:
      begin
        if (req_valid_in)
        begin
          cnt_load = 1'b1;
          if (is_muxed(cfg_in.mode))
          begin
            next_state = EMB_ALE_HI;
            cnt_value = {3'h0, cfg_in.ale_high};
          end
          else if (cfg_in.setup != 2'h0)
          begin
            next_state = EMB_SETUP;
            cnt_value = 5'(cfg_in.setup - 2'h1);
          end
          else
          begin
            next_state = EMB_STROBE;
            cnt_value = {1'b0, cfg_in.pulse};
          end
        end
      end
      EMB_ALE_HI:
        if (cnt_done)
        begin
          next_state = EMB_ALE_LO;
          cnt_load = 1'b1;
          cnt_value = {3'h0, cfg.ale_low};
        end
      EMB_ALE_LO:
        if (cnt_done)
        begin
          cnt_load = 1'b1;
          if (cfg.setup != 2'h0)
          begin
            next_state = EMB_SETUP;
            cnt_value = 5'(cfg.setup - 2'h1);
          end
          else
          begin
            next_state = EMB_STROBE;
            cnt_value = {1'b0, cfg.pulse};
          end
        end
      EMB_SETUP:
        if (cnt_done)
        begin
          next_state = EMB_STROBE;
          cnt_load = 1'b1;
          cnt_value = {1'b0, cfg.pulse};
        end
      EMB_STROBE:
        if (cnt_done)
        begin
          if (cfg.hold != 2'h0)
          begin
            next_state = EMB_HOLD;
            cnt_load = 1'b1;
            cnt_value = 5'(cfg.hold - 2'h1);
          end
          else
            next_state = EMB_IDLE;
        end
      EMB_HOLD:
        if (cnt_done)
          next_state = EMB_IDLE;
      default:
        next_state = EMB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state <= EMB_IDLE;
    else
      state <= next_state;
  end

  // programme and request are frozen for the whole cycle
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cfg <= '0;
      req <= '0;
    end
    else if (state == EMB_IDLE && req_valid_in)
    begin
      cfg <= cfg_in;
      req <= req_in;
    end
  end

  // ************************************************************
  // pin drive, registered from next state
  // ************************************************************
  logic n_active;
  logic n_strobe;
  logic n_ale;
  logic n_mux;
  logic n_bank;
  emb_req_t n_req;
  logic [7:0] n_page;

  always_comb
  begin
    n_active = (next_state != EMB_IDLE);
    n_strobe = (next_state == EMB_STROBE);
    n_ale = (next_state == EMB_ALE_HI);
    n_req = (state == EMB_IDLE) ? req_in : req;
    n_mux = (state == EMB_IDLE) ? is_muxed(cfg_in.mode) : muxed;
    n_bank = (state == EMB_IDLE) ? is_bank(cfg_in.mode) : bank;
    n_page = page_in;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ale_out <= 1'b0;
      wr_n_out <= 1'b1;
      rd_n_out <= 1'b1;
    end
    else
    begin
      ale_out <= n_ale && n_mux;
      wr_n_out <= !(n_strobe && n_req.write);
      rd_n_out <= !(n_strobe && !n_req.write);
    end
  end

  // upper byte: full address, page byte on short-address bank cycles, else untouched
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      addr_hi_out <= EMB_ADDR_RESET[15:8];
      addr_hi_oe_out <= 1'b0;
    end
    else if (n_active && !n_req.short_addr)
    begin
      addr_hi_out <= n_req.addr[15:8];
      addr_hi_oe_out <= 1'b1;
    end
    else if (n_active && n_bank)
    begin
      addr_hi_out <= n_page;
      addr_hi_oe_out <= 1'b1;
    end
    else if (!n_active)
      addr_hi_oe_out <= 1'b0;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      addr_lo_out <= EMB_ADDR_RESET[7:0];
      addr_lo_oe_out <= 1'b0;
    end
    else
    begin
      addr_lo_out <= n_req.addr[7:0];
      addr_lo_oe_out <= n_active && !n_mux;
    end
  end

  // shared lines carry the address during latch high, then write data
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      ad_out <= EMB_DATA_RESET;
      ad_oe_out <= 1'b0;
    end
    else if (n_mux && n_ale)
    begin
      ad_out <= n_req.addr[7:0];
      ad_oe_out <= 1'b1;
    end
    else if (n_active && n_req.write && next_state != EMB_ALE_LO)
    begin
      ad_out <= n_req.wdata;
      ad_oe_out <= 1'b1;
    end
    else
      ad_oe_out <= 1'b0;
  end

  // ************************************************************
  // handshake and read capture
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= EMB_DATA_RESET;
    end
    else
    begin
      req_ready_out <= (next_state == EMB_IDLE);
      done_out <= (state != EMB_IDLE) && (next_state == EMB_IDLE);
      if (state == EMB_STROBE && cnt_done && !req.write)
        rdata_out <= ad_in;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_ale_max;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(ale_out) |-> ##[1:4] !ale_out;
  endproperty
  a_ale_max: assert property (p_ale_max)
    else $error("latch enable high too long");

  property p_ale_low;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $fell(ale_out) |-> !ale_out && rd_n_out && wr_n_out;
  endproperty
  a_ale_low: assert property (p_ale_low)
    else $error("strobe right after latch enable");

  property p_ale_addr;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      ale_out |-> ad_oe_out && ad_out == req.addr[7:0];
  endproperty
  a_ale_addr: assert property (p_ale_addr)
    else $error("shared lines not carrying address");

  property p_wr_data;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      !wr_n_out |-> ad_oe_out && ad_out == req.wdata;
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("write data not valid under strobe");

  property p_wr_hold;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(wr_n_out) && cfg.hold != 2'h0 |-> ad_oe_out;
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write data dropped inside hold");

  property p_nmx_no_ale;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      addr_lo_oe_out |-> !ale_out;
  endproperty
  a_nmx_no_ale: assert property (p_nmx_no_ale)
    else $error("latch enable in non-muxed cycle");

  property p_bank_hi;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      state != EMB_IDLE && req.short_addr && bank |->
        addr_hi_oe_out && addr_hi_out == $past(page_in, 1);
  endproperty
  a_bank_hi: assert property (p_bank_hi)
    else $error("page byte not on upper address");

  property p_hold_len;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      state == EMB_STROBE && cnt_done && cfg.hold == 2'h3 |=> state == EMB_HOLD [*3] ##1 state == EMB_IDLE;
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("hold phase length wrong");

  property p_setup_len;
    @(posedge ref_clk_in) disable iff (!reset_n_in)
      $rose(state == EMB_SETUP) && cfg.setup == 2'h2 |-> state == EMB_SETUP [*2] ##1 state == EMB_STROBE;
  endproperty
  a_setup_len: assert property (p_setup_len)
    else $error("setup phase length wrong");

  c_mux_write: cover property (@(posedge ref_clk_in) ale_out ##[1:8] !wr_n_out);
  c_nmx_read: cover property (@(posedge ref_clk_in) addr_lo_oe_out && !rd_n_out);
  c_bank: cover property (@(posedge ref_clk_in) req.short_addr && bank && addr_hi_oe_out);
endmodule
`default_nettype wire

// file: tb/emb_sram_model.sv
// Purpose: behavioural external byte memory behind the bus pins
// Assumes: muxed_in tells the board wiring (external low byte latch)
// Notes: unselected data lines show the inverse of the last read byte
`default_nettype none
module emb_sram_model
  import emb_pkg::*;
(
  input wire logic ref_clk_in, // system clock
  input wire logic muxed_in, // board uses the low address latch
  input wire logic [7:0] ad_out, // shared or data lines from device
  input wire logic [7:0] addr_hi_out, // upper address lines
  input wire logic addr_hi_oe_out, // upper address driven
  input wire logic [7:0] addr_lo_out, // low address lines
  input wire logic ale_out, // address latch enable
  input wire logic wr_n_out, // write strobe
  input wire logic rd_n_out, // read strobe
  output logic [7:0] ad_in // data lines back to device
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  logic [7:0] latch_lo = 8'h00;
  logic [7:0] last_rd = 8'h00;
  logic [15:0] addr;
  // undriven upper lines read as zero, so short cycles stay consistent
  assign addr = {addr_hi_oe_out ? addr_hi_out : 8'h00,
                 muxed_in ? latch_lo : addr_lo_out};
  always @(posedge ref_clk_in)
  begin
    if (ale_out)
      latch_lo <= ad_out;
    if (!wr_n_out)
      mem[addr] <= ad_out;
    if (!rd_n_out)
      last_rd <= mem[addr];
  end
  // no pull-up on these lines, so released data must not look stable
  assign ad_in = !rd_n_out ? mem[addr] : ~last_rd;
endmodule
`default_nettype wire

// file: tb/external_memory_bus_timing_bench.sv
// Purpose: self-checking bench for the external bus cycle generator
// Assumes: inputs change on the falling edge, outputs read there too
// Notes: every mode code is run with write then read-back
`default_nettype none
module external_memory_bus_timing_bench;
  import emb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  emb_cfg_t cfg = '0;
  emb_req_t req = '0;
  logic req_valid = 1'b0;
  logic [7:0] page = 8'h00;
  logic [7:0] ad_in, rdata, hi, lo, ad, ale_lo, lo_seen, hi_seen, wd_seen;
  logic ready, done, hi_oe, lo_oe, ad_oe, ale, wr_n, rd_n, hi_oe_seen;
  logic lo_oe_seen;
  int n_errors = 0;
  int n_checks = 0;
  int n, ale_n, pre_n, str_n, post_n;

  always #12.5 ref_clk_in = ~ref_clk_in;

  emb_ctrl u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .cfg_in(cfg), .page_in(page), .req_valid_in(req_valid), .req_in(req),
    .ad_in(ad_in), .req_ready_out(ready), .done_out(done),
    .rdata_out(rdata), .addr_hi_out(hi), .addr_hi_oe_out(hi_oe),
    .addr_lo_out(lo), .addr_lo_oe_out(lo_oe), .ad_out(ad),
    .ad_oe_out(ad_oe), .ale_out(ale), .wr_n_out(wr_n), .rd_n_out(rd_n));

  emb_sram_model u_mem (.ref_clk_in(ref_clk_in), .muxed_in(~cfg.mode[2]),
    .ad_out(ad), .addr_hi_out(hi), .addr_hi_oe_out(hi_oe),
    .addr_lo_out(lo), .ale_out(ale), .wr_n_out(wr_n), .rd_n_out(rd_n),
    .ad_in(ad_in));

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t count got %0d exp %0d", $time, got, exp);
    end
  endtask

  // one bus cycle; phase lengths are counted at each falling edge
  task automatic run(input emb_cfg_t c, input logic w, input logic s,
                     input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_in);
    cfg = c;
    req = '{write: w, short_addr: s, addr: a, wdata: d};
    req_valid = 1'b1;
    chk8({7'h00, ready}, 8'h01);
    @(negedge ref_clk_in);
    req_valid = 1'b0;
    {n, ale_n, pre_n, str_n, post_n} = '0;
    repeat (100)
    begin
      n++;
      if (ale === 1'b1)
      begin
        ale_n++;
        ale_lo = ad;
      end
      else if (wr_n === 1'b0 || rd_n === 1'b0)
      begin
        str_n++;
        {hi_seen, hi_oe_seen, lo_seen} = {hi, hi_oe, lo};
        lo_oe_seen = lo_oe;
        wd_seen = ad_oe ? ad : ~d;
      end
      else if (str_n == 0)
        pre_n++;
      else if (ad_oe === 1'b1)
        post_n++;
      if (done === 1'b1)
        break;
      @(negedge ref_clk_in);
    end
  endtask

  localparam logic [2:0] MT [6] = '{EMB_MODE_MUX_NB0, EMB_MODE_MUX_BANK,
    EMB_MODE_MUX_NB1, EMB_MODE_NMX_NB0, EMB_MODE_NMX_BANK, EMB_MODE_NMX_NB1};

  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (2) @(negedge ref_clk_in);
    for (int i = 0; i < 6; i++)
      for (int s = 0; s < 2; s++)
        for (int w = 1; w >= 0; w--)
        begin
          emb_cfg_t c;
          logic mux, bank;
          logic [15:0] a;
          logic [7:0] d;
          c = '{mode: MT[i], setup: 2'(i % 4), pulse: 4'(i * 3),
                hold: 2'((i + 2) % 4), ale_high: 2'(i % 4),
                ale_low: 2'((i + 1) % 4)};
          mux = ~MT[i][2];
          bank = (MT[i] == EMB_MODE_MUX_BANK) ||
                 (MT[i] == EMB_MODE_NMX_BANK);
          a = {8'(8'h40 + i), 8'(8'h11 + i * 16 + s)};
          d = 8'(8'hC3 ^ (i * 8 + s));
          page = 8'(8'h3C + i);
          run(c, w[0], s[0], a, d);
          chkn(n, (mux ? c.ale_high + c.ale_low + 2 : 0) + c.setup +
               c.pulse + c.hold + 2);
          chkn(ale_n, mux ? c.ale_high + 1 : 0);
          chkn(pre_n, (mux ? c.ale_low + 1 : 0) + c.setup);
          chkn(str_n, c.pulse + 1);
          chkn(post_n, w ? c.hold : 0);
          chk8({7'h00, hi_oe_seen}, {7'h00, ~s[0] | bank});
          chk8({7'h00, lo_oe_seen}, {7'h00, ~mux});
          if (!s[0] || bank)
            chk8(hi_seen, s[0] ? page : a[15:8]);
          if (mux)
            chk8(ale_lo, a[7:0]);
          else
            chk8(lo_seen, a[7:0]);
          if (w)
            chk8(wd_seen, d);
          else
            chk8(rdata, d);
        end
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
